// ### core/flash_cmd_defines.svh
// opcode, identity field and timing constants of the flash command block
`ifndef FLASH_CMD_DEFINES_SVH
`define FLASH_CMD_DEFINES_SVH

`define OP_READ_JEDEC_IDENT 8'h9F
`define OP_READ_LEGACY_SIG 8'hAB
`define OP_READ_MAKER_DEV_IDENT 8'h90
`define OP_ENTER_LOCKED_OTP 8'hB1
`define OP_LEAVE_LOCKED_OTP 8'hC1
`define OP_GUARD_REG_READ 8'h2B
`define OP_GUARD_REG_WRITE 8'h2F
`define OP_NO_OP_CMD 8'h00
`define OP_SOFT_REBOOT_ARM 8'h66
`define OP_SOFT_REBOOT_GO 8'h99
`define OP_WRITE_ENABLE_CMD 8'h06
`define OP_WRITE_DISABLE_CMD 8'h04
`define OP_PAGE_WRITE_CMD 8'h02
`define OP_QUAD_PAGE_WRITE_CMD 8'h38
`define OP_SMALL_REGION_WIPE_CMD 8'h20
`define OP_REGION32K_WIPE_CMD 8'h52
`define OP_REGION64K_WIPE_CMD 8'hD8
`define OP_FULL_WIPE_A 8'h60
`define OP_FULL_WIPE_B 8'hC7
`define OP_STATUS_WRITE_CMD 8'h01
`define OP_SUSPEND_A 8'h75
`define OP_SUSPEND_B 8'hB0
`define OP_RESUME_A 8'h7A
`define OP_RESUME_B 8'h30

`define OPCODE_LAST_BIT 6'h07
`define DUMMY_LAST_BIT 6'h1F
`define BIT_CNT_MAX 6'h28

`define GUARD_OTP_BIT 0
`define GUARD_LOCK_BIT 1
`define GUARD_RESET 8'h00

`define REF_CLK_MHZ 25
`define OP_BUSY_US 10
`define OP_BUSY_CYCLES (`OP_BUSY_US * `REF_CLK_MHZ)

`endif

// ### core/flash_cmd_pkg.sv
// types shared by the flash command block
package flash_cmd_pkg;

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_BUSY = 3'b010,
      ST_SUSP = 3'b100
   } core_state_type;

   typedef enum logic [4:0]
   {
      LM_NONE = 5'b00001,
      LM_JEDEC = 5'b00010,
      LM_SIG = 5'b00100,
      LM_MAKER = 5'b01000,
      LM_GUARD = 5'b10000
   } link_mode_type;

endpackage : flash_cmd_pkg

// ### core/cmd_xfer_if.sv
// opcode hand-over from the serial link domain to the core domain
`timescale 1ns/1ps
interface cmd_xfer_if;
   logic tgl;
   logic [7:0] word;
   logic valid;
   logic [7:0] op;

   modport link_side (output tgl, output word, input valid, input op);
   modport rx_side (input tgl, input word, output valid, output op);
endinterface : cmd_xfer_if

// ### core/cmd_rx.sv
// core-side receiver of the toggle-flagged opcode crossing
`timescale 1ns/1ps
module cmd_rx
(
   input wire logic ref_clk_i, // core clock
   input wire logic rst_b_i, // asynchronous reset, active low
   cmd_xfer_if.rx_side xfer // opcode crossing
);
   logic [2:0] tgl_sync_r;
   logic valid_r;
   logic [7:0] op_r;
   wire new_cmd;

   // word is stable long before its toggle is seen here
   assign new_cmd = tgl_sync_r[2] ^ tgl_sync_r[1];
   assign xfer.valid = valid_r;
   assign xfer.op = op_r;

   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         tgl_sync_r <= 3'h0;
         valid_r <= 1'b0;
         op_r <= 8'h00;
      end
      else
      begin
         tgl_sync_r <= {tgl_sync_r[1:0], xfer.tgl};
         valid_r <= new_cmd;
         if (new_cmd)
         begin
            op_r <= xfer.word;
         end
      end
   end
endmodule : cmd_rx

// ### core/flash_cmd_top.sv
// serial flash identity, reset and write-enable command block
//
// Behaviour
// - identity opcode shifts out maker byte then two device bytes, 24 bits repeated.
// - chip select rising at any bit ends identity output and releases the line.
// - identity opcode is not decoded while program or erase runs.
// - chip select high after identity read returns link to standby.
// - legacy signature: three dummy bytes, then the device byte returned repeatedly.
// - maker/device read: two dummies, address 00 maker first, 01 device first.
// - one opcode enters locked OTP mode, another returns to normal array.
// - soft reset only when arm opcode immediately precedes execute opcode.
// - any other command between arm and execute cancels the execute.
// - write-enable opcode sets the write-enable latch unless program or erase runs.
// - upper data lines are ignored during write-enable and write-disable.
// - write-disable opcode clears the write-enable latch.
// - latch clears on reset, suspend, write-disable, status write, program, erase, soft reset.
// - guard register write completion also clears the write-enable latch.
// - program and erase opcodes are ignored without the write-enable latch.
// - identity bits leave on falling serial clock edges, most significant first.
`timescale 1ns/1ps
`include "flash_cmd_defines.svh"
module flash_cmd_top
   import flash_cmd_pkg::*;
#(
   parameter logic [7:0] MAKER_ID = 8'hA5, // arbitrary value
   parameter logic [7:0] MEM_TYPE_ID = 8'h5A, // arbitrary value
   parameter logic [7:0] DENSITY_ID = 8'h15, // arbitrary value
   parameter logic [7:0] DEVICE_ID = 8'h14, // arbitrary value
   parameter int BUSY_CYCLES = `OP_BUSY_CYCLES
)
(
   input wire logic ref_clk_i, // core clock, 25 MHz
   input wire logic rst_b_i, // reset pin and power-up, active low
   input wire logic sclk_i, // serial clock from host
   input wire logic cs_b_i, // chip select, active low
   input wire logic si_i, // serial data in
   input wire logic [2:0] upper_io_lines_i, // unused upper data lines
   output logic so_o, // serial data out
   output logic so_oe_b_o, // serial out enable, low while driving
   output logic write_enable_latch_o, // latch state
   output logic locked_otp_o, // locked OTP mode active
   output logic busy_o, // program or erase running
   output logic suspended_o, // program or erase suspended
   output logic lock_down_o, // guard lock-down bit
   output logic soft_reset_o // one-cycle soft reset pulse
);
   // upper_io_lines_i is never read: single-byte commands take data on si_i only

   function automatic logic is_pe_op(input logic [7:0] op);
      is_pe_op = (op == `OP_PAGE_WRITE_CMD) || (op == `OP_QUAD_PAGE_WRITE_CMD) ||
                 (op == `OP_SMALL_REGION_WIPE_CMD) || (op == `OP_REGION32K_WIPE_CMD) ||
                 (op == `OP_REGION64K_WIPE_CMD) || (op == `OP_FULL_WIPE_A) ||
                 (op == `OP_FULL_WIPE_B) || (op == `OP_STATUS_WRITE_CMD);
   endfunction : is_pe_op

   function automatic logic is_op(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b);
      is_op = (op == a) || (op == b);
   endfunction : is_op

   cmd_xfer_if xfer ();

   cmd_rx u_cmd_rx
   (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .xfer(xfer.rx_side)
   );

   // ---------------- link domain (sclk_i) ----------------
   logic [5:0] bit_cnt_r;
   logic [6:0] in_sh_r;
   link_mode_type mode_r;
   link_mode_type mode_nxt;
   logic [47:0] resp_r;
   logic [47:0] resp_nxt;
   logic drive_r;
   logic drive_nxt;
   logic so_r;
   logic so_oe_b_r;
   logic tgl_r;
   logic [7:0] word_r;
   logic busy_s1_r;
   logic busy_s2_r;
   logic [1:0] guard_s1_r;
   logic [1:0] guard_s2_r;

   wire link_clr;
   wire [7:0] in_byte;
   wire at_opcode;
   wire at_dummy_end;
   wire [7:0] guard_link;
   wire [7:0] first_id;
   wire [7:0] second_id;
   wire load_ready;
   wire [47:0] load_val;

   // frame logic clears while deselected; the serial clock may stand still then
   assign link_clr = cs_b_i | ~rst_b_i;
   assign in_byte = {in_sh_r, si_i};
   assign at_opcode = (bit_cnt_r == `OPCODE_LAST_BIT);
   assign at_dummy_end = (bit_cnt_r == `DUMMY_LAST_BIT);
   assign guard_link = {6'h00, guard_s2_r};
   assign first_id = in_byte[0] ? DEVICE_ID : MAKER_ID;
   assign second_id = in_byte[0] ? MAKER_ID : DEVICE_ID;

   always_comb
   begin
      mode_nxt = mode_r;
      if (at_opcode)
      begin
         case (in_byte)
            `OP_READ_JEDEC_IDENT: mode_nxt = busy_s2_r ? LM_NONE : LM_JEDEC;
            `OP_READ_LEGACY_SIG: mode_nxt = LM_SIG;
            `OP_READ_MAKER_DEV_IDENT: mode_nxt = LM_MAKER;
            `OP_GUARD_REG_READ: mode_nxt = LM_GUARD;
            default: mode_nxt = LM_NONE;
         endcase
      end
   end

   // a load takes over from the shift; any other mode stops driving
   assign load_ready = (((mode_nxt == LM_JEDEC) || (mode_nxt == LM_GUARD)) && at_opcode)
                     || (((mode_nxt == LM_SIG) || (mode_nxt == LM_MAKER)) && at_dummy_end);
   assign load_val = (mode_nxt == LM_JEDEC) ? {2{MAKER_ID, MEM_TYPE_ID, DENSITY_ID}}
                   : (mode_nxt == LM_GUARD) ? {6{guard_link}}
                   : (mode_nxt == LM_SIG) ? {6{DEVICE_ID}}
                   : {3{first_id, second_id}};
   assign resp_nxt = load_ready ? load_val : (drive_r ? {resp_r[46:0], resp_r[47]} : resp_r);
   assign drive_nxt = load_ready || (drive_r && (mode_nxt != LM_NONE));

   always_ff @(posedge sclk_i or posedge link_clr)
   begin
      if (link_clr)
      begin
         bit_cnt_r <= 6'h00;
         in_sh_r <= 7'h00;
         mode_r <= LM_NONE;
         resp_r <= 48'h000000000000;
         drive_r <= 1'b0;
      end
      else
      begin
         bit_cnt_r <= (bit_cnt_r == `BIT_CNT_MAX) ? bit_cnt_r : bit_cnt_r + 6'h01;
         in_sh_r <= in_byte[6:0];
         mode_r <= mode_nxt;
         resp_r <= resp_nxt;
         drive_r <= drive_nxt;
      end
   end

   // output changes on the falling edge, so the host samples a settled bit
   always_ff @(negedge sclk_i or posedge link_clr)
   begin
      if (link_clr)
      begin
         so_r <= 1'b0;
         so_oe_b_r <= 1'b1;
      end
      else
      begin
         so_r <= drive_r & resp_r[47];
         so_oe_b_r <= ~drive_r;
      end
   end

   // opcode crossing survives chip select, only the toggle marks a new word
   always_ff @(posedge sclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         tgl_r <= 1'b0;
         word_r <= 8'h00;
      end
      else if (!cs_b_i && at_opcode)
      begin
         tgl_r <= ~tgl_r;
         word_r <= in_byte;
      end
   end

   // core levels only refresh on serial clock edges; the opcode byte settles them
   always_ff @(posedge sclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         busy_s1_r <= 1'b0;
         busy_s2_r <= 1'b0;
         guard_s1_r <= 2'b00;
         guard_s2_r <= 2'b00;
      end
      else
      begin
         busy_s1_r <= busy_o;
         busy_s2_r <= busy_s1_r;
         guard_s1_r <= {lock_down_o, locked_otp_o};
         guard_s2_r <= guard_s1_r;
      end
   end

   assign xfer.tgl = tgl_r;
   assign xfer.word = word_r;
   assign so_o = so_r;
   assign so_oe_b_o = so_oe_b_r;

   // ---------------- core domain (ref_clk_i) ----------------
   core_state_type state_r;
   core_state_type state_nxt;
   logic [15:0] busy_cnt_r;
   logic [15:0] busy_cnt_nxt;
   logic wel_r;
   logic otp_r;
   logic lock_r;
   logic arm_r;
   logic soft_rst_r;
   logic busy_r;
   logic susp_r;

   wire cmd_v;
   wire [7:0] cmd;
   wire do_soft_rst;
   wire pe_accept;
   wire pe_done;
   wire do_suspend;
   wire do_resume;
   wire wel_set;
   wire wel_clr;
   wire wel_nxt;
   wire otp_nxt;
   wire lock_nxt;

   assign cmd_v = xfer.valid;
   assign cmd = xfer.op;
   assign do_soft_rst = cmd_v && (cmd == `OP_SOFT_REBOOT_GO) && arm_r;
   assign pe_accept = cmd_v && is_pe_op(cmd) && wel_r && (state_r == ST_IDLE);
   assign pe_done = (state_r == ST_BUSY) && (busy_cnt_r == 16'h0000);
   assign do_suspend = cmd_v && is_op(cmd, `OP_SUSPEND_A, `OP_SUSPEND_B) && (state_r == ST_BUSY);
   assign do_resume = cmd_v && is_op(cmd, `OP_RESUME_A, `OP_RESUME_B) && (state_r == ST_SUSP);
   assign wel_set = cmd_v && (cmd == `OP_WRITE_ENABLE_CMD) && (state_r != ST_BUSY);
   assign wel_clr = (cmd_v && (cmd == `OP_WRITE_DISABLE_CMD))
                  || (cmd_v && (cmd == `OP_GUARD_REG_WRITE))
                  || pe_done || do_suspend || do_soft_rst;
   assign wel_nxt = wel_set ? 1'b1 : (wel_clr ? 1'b0 : wel_r);
   assign otp_nxt = do_soft_rst ? 1'b0 : (cmd_v && (cmd == `OP_ENTER_LOCKED_OTP)) ? 1'b1
                  : (cmd_v && (cmd == `OP_LEAVE_LOCKED_OTP)) ? 1'b0 : otp_r;
   assign lock_nxt = lock_r | (cmd_v && (cmd == `OP_GUARD_REG_WRITE));

   always_comb
   begin
      state_nxt = state_r;
      busy_cnt_nxt = busy_cnt_r;
      case (state_r)
         ST_IDLE:
         begin
            if (pe_accept)
            begin
               state_nxt = ST_BUSY;
               busy_cnt_nxt = 16'(BUSY_CYCLES - 1);
            end
         end
         ST_BUSY:
         begin
            if (do_suspend)
            begin
               state_nxt = ST_SUSP;
            end
            else if (pe_done)
            begin
               state_nxt = ST_IDLE;
            end
            else
            begin
               busy_cnt_nxt = busy_cnt_r - 16'h0001;
            end
         end
         ST_SUSP:
         begin
            if (do_resume)
            begin
               state_nxt = ST_BUSY;
            end
         end
         default:
         begin
            state_nxt = ST_IDLE;
            busy_cnt_nxt = 16'h0000;
         end
      endcase
      if (do_soft_rst)
      begin
         state_nxt = ST_IDLE;
         busy_cnt_nxt = 16'h0000;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state_r <= ST_IDLE;
         busy_cnt_r <= 16'h0000;
         busy_r <= 1'b0;
         susp_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         busy_cnt_r <= busy_cnt_nxt;
         busy_r <= (state_nxt == ST_BUSY);
         susp_r <= (state_nxt == ST_SUSP);
      end
   end

   // reset pin clears the latch; lock-down is one-time, only the reset pin models a fresh part
   // any decoded opcode, no-op included, replaces the arm state
   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         wel_r <= 1'b0;
         otp_r <= 1'b0;
         lock_r <= 1'(`GUARD_RESET >> `GUARD_LOCK_BIT);
         arm_r <= 1'b0;
         soft_rst_r <= 1'b0;
      end
      else
      begin
         wel_r <= wel_nxt;
         otp_r <= otp_nxt;
         lock_r <= lock_nxt;
         if (cmd_v)
         begin
            arm_r <= (cmd == `OP_SOFT_REBOOT_ARM);
         end
         soft_rst_r <= do_soft_rst;
      end
   end

   assign write_enable_latch_o = wel_r;
   assign locked_otp_o = otp_r;
   assign busy_o = busy_r;
   assign suspended_o = susp_r;
   assign lock_down_o = lock_r;
   assign soft_reset_o = soft_rst_r;
endmodule : flash_cmd_top

// ### verif/flash_cmd_monitor.sv
// port assertions of the flash command block
`timescale 1ns/1ps
module flash_cmd_monitor
#(
   parameter int BUSY_CYCLES = 250
)
(
   input wire logic ref_clk_i, // core clock
   input wire logic rst_b_i, // reset, active low
   input wire logic sclk_i, // serial clock
   input wire logic cs_b_i, // chip select, active low
   input wire logic si_i, // serial in
   input wire logic [2:0] upper_io_lines_i, // upper data lines
   input wire logic so_o, // serial out
   input wire logic so_oe_b_o, // out enable, active low
   input wire logic write_enable_latch_o, // latch
   input wire logic locked_otp_o, // otp mode
   input wire logic busy_o, // operation running
   input wire logic suspended_o, // operation suspended
   input wire logic lock_down_o, // lock-down bit
   input wire logic soft_reset_o // soft reset pulse
);
   int run_r;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);

   // busy cycles of one operation, held across a suspension
   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         run_r <= 0;
      else if (!busy_o && !suspended_o)
         run_r <= 0;
      else if ($rose(suspended_o))
         run_r <= run_r - 1;
      else if (busy_o)
         run_r <= run_r + 1;
   end

   property p_oe_off; cs_b_i |-> so_oe_b_o; endproperty
   a_oe_off: assert property (p_oe_off) else $error("driving while deselected");
   property p_so_idle; so_oe_b_o |-> !so_o; endproperty
   a_so_idle: assert property (p_so_idle) else $error("data out while released");
   property p_soft_pulse; soft_reset_o |=> !soft_reset_o; endproperty
   a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset pulse too long");
   property p_soft_clear;
      soft_reset_o |=> !(write_enable_latch_o || locked_otp_o || busy_o || suspended_o);
   endproperty
   a_soft_clear: assert property (p_soft_clear) else $error("state kept over soft reset");
   property p_lock_sticky; lock_down_o |=> lock_down_o; endproperty
   a_lock_sticky: assert property (p_lock_sticky) else $error("lock-down bit cleared");
   property p_done_len;
      $fell(busy_o) |-> (run_r == BUSY_CYCLES) or ##[0:1] suspended_o or soft_reset_o or $past(soft_reset_o);
   endproperty
   a_done_len: assert property (p_done_len) else $error("operation length wrong");
   property p_run_max; busy_o |-> run_r < BUSY_CYCLES; endproperty
   a_run_max: assert property (p_run_max) else $error("operation overran");
   property p_done_wel; $fell(busy_o) |-> ##[0:1] !write_enable_latch_o; endproperty
   a_done_wel: assert property (p_done_wel) else $error("latch kept after operation");
   property p_start_wel; $rose(busy_o) && !$past(suspended_o) |-> $past(write_enable_latch_o); endproperty
   a_start_wel: assert property (p_start_wel) else $error("operation without latch");
   property p_susp_wel; $rose(suspended_o) |-> ##[0:1] !write_enable_latch_o; endproperty
   a_susp_wel: assert property (p_susp_wel) else $error("latch kept over suspend");
endmodule : flash_cmd_monitor

// ### verif/spi_host_model.sv
// serial host model sending opcode frames to the device
`timescale 1ns/1ps
module spi_host_model
(
   output logic sclk_o, // serial clock, runs only in frames
   output logic cs_b_o, // chip select, active low
   output logic si_o, // serial data to device
   input wire logic so_i, // serial data from device
   input wire logic so_oe_b_i // device out enable, active low
);
   initial
   begin
      sclk_o = 1'b0;
      cs_b_o = 1'b1;
      si_o = 1'b0;
   end

   // one frame: n_tx bits msb first, then n_rx bits read; ok drops if device idle on a read bit
   task automatic frame(input logic [39:0] tx, input int n_tx, input int n_rx,
      output logic [47:0] rx, output logic ok);
      rx = '0;
      ok = 1'b1;
      cs_b_o = 1'b0;
      for (int i = 0; i < n_tx + n_rx; i++)
      begin
         // inverted data once the n_tx bits are out, so nothing stale looks valid
         si_o = (i < n_tx) ? tx[n_tx - 1 - i] : ~si_o;
         #6 sclk_o = 1'b1;
         if (i >= n_tx)
         begin
            // a released line shows the inverse of the last bit, there is no pull
            rx = {rx[46:0], so_oe_b_i ? ~rx[0] : so_i};
            ok = ok & ~so_oe_b_i;
         end
         #6 sclk_o = 1'b0;
      end
      #6 cs_b_o = 1'b1;
      si_o = ~si_o;
   endtask : frame
endmodule : spi_host_model

// ### verif/testbench.sv
// self-checking bench of the flash command block
`timescale 1ns/1ps
module testbench;
   import flash_cmd_pkg::*;
   // arbitrary identity values
   localparam logic [7:0] MK = 8'h3C;
   localparam logic [7:0] MT = 8'h6E;
   localparam logic [7:0] DN = 8'h17;
   localparam logic [7:0] DV = 8'h16;
   logic ref_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [2:0] upper = 3'h0;
   logic sclk, cs_b, si, so, oe_b, write_enable_latch, otp, busy, susp, lock, srst, ok;
   logic [47:0] rx;
   logic [31:0] seed = 32'hAD6DAFBC;
   logic [7:0] ops[8] = '{8'h02, 8'h38, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7, 8'h01};
   int fail_count = 0;
   int n_tests = 0;
   int pulses = 0;
   int n;

   always #20 ref_clk_i = ~ref_clk_i;

   flash_cmd_top #(.MAKER_ID(MK), .MEM_TYPE_ID(MT), .DENSITY_ID(DN), .DEVICE_ID(DV), .BUSY_CYCLES(40)) u_dut (
      .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .sclk_i(sclk), .cs_b_i(cs_b), .si_i(si),
      .upper_io_lines_i(upper), .so_o(so), .so_oe_b_o(oe_b), .write_enable_latch_o(write_enable_latch),
      .locked_otp_o(otp), .busy_o(busy), .suspended_o(susp), .lock_down_o(lock), .soft_reset_o(srst));
   spi_host_model u_host (.sclk_o(sclk), .cs_b_o(cs_b), .si_o(si), .so_i(so), .so_oe_b_i(oe_b));

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   // identity stream of a read opcode, first n bits kept
   function automatic logic [47:0] exp_seq(input logic [7:0] op, input logic a0, input int n);
      logic [47:0] s;
      s = '0;
      for (int i = 0; i < 6; i++)
         s = {s[39:0], op == 8'h9F ? (i % 3 == 0 ? MK : i % 3 == 1 ? MT : DN) :
            op == 8'hAB ? DV : (i[0] ^ a0) ? DV : MK};
      return s >> (48 - n);
   endfunction : exp_seq

   always @(negedge ref_clk_i) upper <= 3'(xs());
   always @(posedge ref_clk_i) if (srst === 1'b1) pulses++;

   task automatic check(input logic [47:0] got, input logic [47:0] exp, input string msg);
      n_tests++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : check

   // the core acts 3-4 cycles after the opcode, so 6 cycles of gap suffice
   task automatic cmd(input logic [39:0] tx, input int n_tx, input int n_rx);
      @(negedge ref_clk_i);
      u_host.frame(tx, n_tx, n_rx, rx, ok);
      repeat (6) @(negedge ref_clk_i);
   endtask : cmd

   task automatic wait_idle();
      for (int k = 0; k < 200 && busy !== 1'b0; k++)
         @(negedge ref_clk_i);
   endtask : wait_idle

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude

   initial
   begin
      #500us;
      fail_count++;
      conclude();
   end

   initial
   begin
      repeat (20) @(negedge ref_clk_i);
      rst_b_i = 1'b1;
      @(negedge ref_clk_i);
      check({write_enable_latch, otp, busy, susp, lock, srst, oe_b}, 7'h01, "reset state");
      cmd(40'h9F, 8, 48);
      check(rx, exp_seq(8'h9F, 1'b0, 48), "ident");
      check(ok, 1'b1, "ident driven");
      n = 1 + xs() % 23;
      cmd(40'h9F, 8, n);
      check(rx, exp_seq(8'h9F, 1'b0, 48) >> (48 - n), "ident cut");
      check(oe_b, 1'b1, "released");
      cmd({8'hAB, 24'(xs())}, 32, 16);
      check(rx, exp_seq(8'hAB, 1'b0, 16), "signature");
      for (int a = 0; a < 2; a++)
      begin
         cmd({8'h90, 16'(xs()), 7'h00, 1'(a)}, 32, 16);
         check(rx, exp_seq(8'h90, 1'(a), 16), "maker dev");
      end
      $display("identity reads done");
      cmd(40'hB1, 8, 0);
      check(otp, 1'b1, "otp on");
      cmd(40'h2B, 8, 8);
      check(rx, 48'h01, "guard read");
      cmd(40'hC1, 8, 0);
      check(otp, 1'b0, "otp off");
      cmd(40'h06, 8, 0);
      check(write_enable_latch, 1'b1, "latch set");
      cmd(40'h04, 8, 0);
      check(write_enable_latch, 1'b0, "latch clear");
      $display("mode and latch done");
      foreach (ops[j])
      begin
         cmd(ops[j], 8, 0);
         check(busy, 1'b0, "no latch");
         cmd(40'h06, 8, 0);
         cmd(ops[j], 8, 0);
         check(busy, 1'b1, "started");
         cmd(40'h9F, 8, 8);
         check(ok, 1'b0, "ident while busy");
         wait_idle();
         check(write_enable_latch, 1'b0, "latch after op");
      end
      $display("operations done");
      cmd(40'h06, 8, 0);
      cmd(40'h20, 8, 0);
      cmd(40'h75, 8, 0);
      check({susp, busy, write_enable_latch}, 3'b100, "suspended");
      cmd(40'h7A, 8, 0);
      check({susp, busy}, 2'b01, "resumed");
      wait_idle();
      cmd(40'h06, 8, 0);
      cmd(40'h2F, 8, 0);
      check({lock, write_enable_latch}, 2'b10, "lock down");
      $display("suspend and guard done");
      cmd(40'h06, 8, 0);
      cmd(40'hB1, 8, 0);
      pulses = 0;
      cmd(40'h66, 8, 0);
      cmd(40'h00, 8, 0);
      cmd(40'h99, 8, 0);
      check({pulses[1:0], write_enable_latch, otp}, 4'b0011, "reset cancelled");
      cmd(40'h66, 8, 0);
      cmd(40'h99, 8, 0);
      check({pulses[1:0], write_enable_latch, otp, lock}, 5'b01001, "soft reset");
      $display("soft reset done");
      conclude();
   end
endmodule : testbench

bind flash_cmd_top flash_cmd_monitor #(.BUSY_CYCLES(BUSY_CYCLES)) u_mon (
   .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .sclk_i(sclk_i), .cs_b_i(cs_b_i), .si_i(si_i),
   .upper_io_lines_i(upper_io_lines_i), .so_o(so_o), .so_oe_b_o(so_oe_b_o),
   .write_enable_latch_o(write_enable_latch_o), .locked_otp_o(locked_otp_o), .busy_o(busy_o),
   .suspended_o(suspended_o), .lock_down_o(lock_down_o), .soft_reset_o(soft_reset_o));
